/* verilog/device_activity_regs.sv */
// Behaviour
// - bits 31..28 select burst timer for monitors 5, 3, 2, 1.
// - select 0 reloads slow burst timer, 1 reloads fast burst timer.
// - burst enable 1 passes monitor events to burst path; 0 ignores them.
// - burst enable bit 14 + n serves monitor n, up to bit 27.
// - global enable 1 lets monitor events reload standby timer; 0 blocks.
// - global enable bit n serves monitor n, bits 13 down to 0.
module device_activity_regs (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [devact_pkg::ADDR_W-1:0] i_addr,
    input wire logic [devact_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [devact_pkg::DATA_W-1:0] o_rdata,
    input wire logic [devact_pkg::MON_COUNT-1:0] i_mon_event,
    input wire logic i_clock_stopped,
    output logic o_standby_reload,
    output logic o_slow_burst_reload,
    output logic o_fast_burst_reload,
    output logic o_stop_break
);
    logic [devact_pkg::DATA_W-1:0] device_activity_enables;
    logic [devact_pkg::DATA_W-1:0] seen;
    logic [devact_pkg::DATA_W-1:0] next_rdata;
    logic [devact_pkg::DATA_W-1:0] seen_set;
    logic [devact_pkg::DATA_W-1:0] seen_clear;
    logic [devact_pkg::MON_COUNT-1:0] standby_allow;
    logic [devact_pkg::MON_COUNT-1:0] burst_allow;
    logic [devact_pkg::PICK_COUNT-1:0] burst_pick;
    logic burst_pick_mon1;
    logic burst_pick_mon2;
    logic burst_pick_mon3;
    logic burst_pick_mon5;
    logic hit_enables;
    logic hit_seen;

    route_if rt ();

    assign rt.enables = device_activity_enables;
    assign rt.events = i_mon_event;
    assign rt.clock_stopped = i_clock_stopped;

    event_router u_router (
        .rt(rt.router)
    );

    assign standby_allow = device_activity_enables[devact_pkg::STANDBY_LSB +: devact_pkg::MON_COUNT];
    assign burst_allow = device_activity_enables[devact_pkg::BURST_LSB +: devact_pkg::MON_COUNT];
    assign burst_pick = device_activity_enables[devact_pkg::PICK_LSB +: devact_pkg::PICK_COUNT];
    assign burst_pick_mon1 = burst_pick[devact_pkg::pick_slot(1)];
    assign burst_pick_mon2 = burst_pick[devact_pkg::pick_slot(2)];
    assign burst_pick_mon3 = burst_pick[devact_pkg::pick_slot(3)];
    assign burst_pick_mon5 = burst_pick[devact_pkg::pick_slot(5)];

    assign hit_enables = (i_addr == devact_pkg::ENABLES_OFFSET);
    assign hit_seen = (i_addr == devact_pkg::SEEN_OFFSET);

    // configuration register, all 32 bits read/write
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            device_activity_enables <= devact_pkg::ENABLES_RESET;
        end else if (i_wr && hit_enables) begin
            device_activity_enables <= i_wdata;
        end
    end

    // routed events leave through flops, one cycle after the monitor pulse
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_standby_reload <= 1'b0;
            o_slow_burst_reload <= 1'b0;
            o_fast_burst_reload <= 1'b0;
            o_stop_break <= 1'b0;
        end else begin
            o_standby_reload <= rt.standby_reload;
            o_slow_burst_reload <= rt.slow_reload;
            o_fast_burst_reload <= rt.fast_reload;
            o_stop_break <= rt.stop_break;
        end
    end

    // sticky activity record, write one to clear; a new event beats the clear
    always_comb begin
        seen_set = devact_pkg::SEEN_RESET;
        seen_set[devact_pkg::SEEN_MON_LSB +: devact_pkg::MON_COUNT] = rt.standby_hit | rt.burst_hit;
        seen_set[devact_pkg::SEEN_STANDBY] = rt.standby_reload;
        seen_set[devact_pkg::SEEN_SLOW] = rt.slow_reload;
        seen_set[devact_pkg::SEEN_FAST] = rt.fast_reload;
        seen_set[devact_pkg::SEEN_BREAK] = rt.stop_break;
        seen_clear = (i_wr && hit_seen) ? i_wdata : devact_pkg::SEEN_RESET;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seen <= devact_pkg::SEEN_RESET;
        end else begin
            seen <= (seen & ~seen_clear) | seen_set;
        end
    end

    // read data only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = devact_pkg::READ_IDLE;
        if (i_rd) begin
            if (hit_enables) begin
                next_rdata = device_activity_enables;
            end else if (hit_seen) begin
                next_rdata = seen;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= devact_pkg::READ_IDLE;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    property p_pick_mon1_fast;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event[1] && burst_allow[1] && burst_pick_mon1 && !i_clock_stopped)
        |=> (o_fast_burst_reload && !o_stop_break);
    endproperty
    a_pick_mon1_fast: assert property (p_pick_mon1_fast) else $error("mon1 fast pick lost");

    property p_pick_mon5_pos;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h0020 && device_activity_enables[31] && burst_allow[5]
            && !i_clock_stopped)
        |=> (o_fast_burst_reload && !o_slow_burst_reload);
    endproperty
    a_pick_mon5_pos: assert property (p_pick_mon5_pos) else $error("bit 31 not mon5 select");

    property p_pick_slow;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h0004 && burst_allow[2] && !burst_pick_mon2 && !i_clock_stopped)
        |=> (o_slow_burst_reload && !o_fast_burst_reload);
    endproperty
    a_pick_slow: assert property (p_pick_slow) else $error("select 0 did not pick slow");

    property p_pick_fast_only;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h0008 && burst_allow[3] && burst_pick_mon3 && !i_clock_stopped)
        |=> (!o_slow_burst_reload ##1 (!o_slow_burst_reload || $past(i_mon_event) != 14'h0000));
    endproperty
    a_pick_fast_only: assert property (p_pick_fast_only) else $error("select 1 hit slow");

    property p_burst_off;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((i_mon_event & burst_allow) == 14'h0000)
        |=> !(o_slow_burst_reload || o_fast_burst_reload || o_stop_break);
    endproperty
    a_burst_off: assert property (p_burst_off) else $error("disabled burst event acted");

    property p_burst_break;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((i_mon_event & burst_allow) != 14'h0000 && i_clock_stopped)
        |=> (o_stop_break && !o_slow_burst_reload && !o_fast_burst_reload);
    endproperty
    a_burst_break: assert property (p_burst_break) else $error("stop break not raised");

    property p_burst_map_top;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h2000 && device_activity_enables[27] && !i_clock_stopped)
        |=> o_fast_burst_reload;
    endproperty
    a_burst_map_top: assert property (p_burst_map_top) else $error("bit 27 not monitor 13");

    property p_burst_map_low;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h0001 && !device_activity_enables[14] && i_clock_stopped)
        |=> !o_stop_break;
    endproperty
    a_burst_map_low: assert property (p_burst_map_low) else $error("bit 14 not monitor 0");

    property p_standby_on;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((i_mon_event & standby_allow) != 14'h0000) |=> o_standby_reload;
    endproperty
    a_standby_on: assert property (p_standby_on) else $error("standby reload missing");

    property p_standby_off;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((i_mon_event & standby_allow) == 14'h0000) |=> !o_standby_reload;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("blocked standby reload");

    property p_standby_map;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h0001 && device_activity_enables[0])
        |=> (o_standby_reload && seen[devact_pkg::SEEN_STANDBY]);
    endproperty
    a_standby_map: assert property (p_standby_map) else $error("bit 0 not monitor 0");

    property p_standby_map_top;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mon_event == 14'h2000 && !device_activity_enables[13]) |=> !o_standby_reload;
    endproperty
    a_standby_map_top: assert property (p_standby_map_top) else $error("bit 13 misrouted");

    property p_both_paths;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((i_mon_event & standby_allow & burst_allow) != 14'h0000)
        |=> (o_standby_reload && (o_slow_burst_reload || o_fast_burst_reload || o_stop_break));
    endproperty
    a_both_paths: assert property (p_both_paths) else $error("dual event not split");

    property p_write_steers;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_wr && hit_enables && i_wdata[0] && !i_rd) ##1 (i_mon_event == 14'h0001)
        |=> o_standby_reload;
    endproperty
    a_write_steers: assert property (p_write_steers) else $error("write did not steer");

    property p_read_back;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && hit_enables) |=> (o_rdata == $past(device_activity_enables));
    endproperty
    a_read_back: assert property (p_read_back) else $error("enables read back wrong");

    property p_read_idle;
        @(posedge i_clk) disable iff (!i_arst_n)
        !i_rd |=> (o_rdata == devact_pkg::READ_IDLE);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside its cycle");

    property p_seen_set_wins;
        @(posedge i_clk) disable iff (!i_arst_n)
        (rt.standby_reload && i_wr && hit_seen) |=> seen[devact_pkg::SEEN_STANDBY];
    endproperty
    a_seen_set_wins: assert property (p_seen_set_wins) else $error("clear beat new event");

endmodule : device_activity_regs

/* pkg/devact_pkg.sv */
package devact_pkg;

    localparam int MON_COUNT = 14;
    localparam int PICK_COUNT = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ENABLES_OFFSET = 8'h54;
    localparam logic [ADDR_W-1:0] SEEN_OFFSET = 8'h60;

    localparam logic [DATA_W-1:0] ENABLES_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SEEN_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

    // field positions inside device_activity_enables
    localparam int STANDBY_LSB = 0;
    localparam int BURST_LSB = 14;
    localparam int PICK_LSB = 28;

    // status bit positions inside the seen register
    localparam int SEEN_MON_LSB = 0;
    localparam int SEEN_STANDBY = 16;
    localparam int SEEN_SLOW = 17;
    localparam int SEEN_FAST = 18;
    localparam int SEEN_BREAK = 19;

    typedef enum logic {
        burst_slow,
        burst_fast
    } burst_kind_t;

    // monitors without a select bit always reload the fast burst timer
    localparam burst_kind_t UNPICKED_KIND = burst_fast;

    // select bit slot of a monitor: 28 -> mon1, 29 -> mon2, 30 -> mon3, 31 -> mon5
    function automatic int pick_slot(input int mon);
        case (mon)
            1: pick_slot = 0;
            2: pick_slot = 1;
            3: pick_slot = 2;
            5: pick_slot = 3;
            default: pick_slot = -1;
        endcase
    endfunction : pick_slot

endpackage : devact_pkg

/* pkg/route_if.sv */
interface route_if;
    logic [devact_pkg::DATA_W-1:0] enables;
    logic [devact_pkg::MON_COUNT-1:0] events;
    logic clock_stopped;
    logic [devact_pkg::MON_COUNT-1:0] standby_hit;
    logic [devact_pkg::MON_COUNT-1:0] burst_hit;
    logic standby_reload;
    logic slow_reload;
    logic fast_reload;
    logic stop_break;

    modport router (
        input enables,
        input events,
        input clock_stopped,
        output standby_hit,
        output burst_hit,
        output standby_reload,
        output slow_reload,
        output fast_reload,
        output stop_break
    );

    modport owner (
        output enables,
        output events,
        output clock_stopped,
        input standby_hit,
        input burst_hit,
        input standby_reload,
        input slow_reload,
        input fast_reload,
        input stop_break
    );
endinterface : route_if

/* verilog/event_router.sv */
module event_router (
    route_if.router rt
);
    logic [devact_pkg::MON_COUNT-1:0] goes_fast;

    for (genvar m = 0; m < devact_pkg::MON_COUNT; m++) begin : g_mon
        assign rt.standby_hit[m] = rt.events[m] & rt.enables[devact_pkg::STANDBY_LSB + m];
        assign rt.burst_hit[m] = rt.events[m] & rt.enables[devact_pkg::BURST_LSB + m];
        if (devact_pkg::pick_slot(m) >= 0) begin : g_pick
            assign goes_fast[m] = rt.enables[devact_pkg::PICK_LSB + devact_pkg::pick_slot(m)];
        end else begin : g_fixed
            assign goes_fast[m] = (devact_pkg::UNPICKED_KIND == devact_pkg::burst_fast);
        end
    end

    // both paths derive from the same event independently
    assign rt.standby_reload = |rt.standby_hit;
    // a stopped clock turns burst activity into a break instead of a reload
    assign rt.slow_reload = ~rt.clock_stopped & |(rt.burst_hit & ~goes_fast);
    assign rt.fast_reload = ~rt.clock_stopped & |(rt.burst_hit & goes_fast);
    assign rt.stop_break = rt.clock_stopped & |rt.burst_hit;
endmodule : event_router

/* test/device_activity_reload_enables_tb_top.sv */
module device_activity_reload_enables_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk;
    logic i_arst_n;
    logic [devact_pkg::ADDR_W-1:0] addr;
    logic [devact_pkg::DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [devact_pkg::DATA_W-1:0] rdata;
    logic [devact_pkg::MON_COUNT-1:0] mon_event;
    logic clock_stopped;
    logic standby;
    logic slow;
    logic fast;
    logic brk;
    logic [31:0] shadow;
    logic [31:0] d;
    int error_cnt;
    int checks_done;
    int cycles;

    device_activity_regs uut (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .i_mon_event(mon_event),
        .i_clock_stopped(clock_stopped),
        .o_standby_reload(standby),
        .o_slow_burst_reload(slow),
        .o_fast_burst_reload(fast),
        .o_stop_break(brk)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // the whole sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
        if (a == devact_pkg::ENABLES_OFFSET) begin
            shadow = v;
        end
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_read

    // expected {standby, slow, fast, stop break}, worked out independently of the design
    function automatic logic [3:0] model(input logic [31:0] r, input logic [13:0] m,
                                         input logic stp);
        logic [3:0] e;
        logic [13:0] b;
        logic k;
        e = 4'h0;
        e[3] = |(m & r[13:0]);
        b = m & r[27:14];
        for (int i = 0; i < 14; i++) begin
            k = (devact_pkg::UNPICKED_KIND == devact_pkg::burst_fast);
            case (i)
                1: k = r[28];
                2: k = r[29];
                3: k = r[30];
                5: k = r[31];
                default: ;
            endcase
            if (b[i] && stp) begin
                e[0] = 1'b1;
            end else if (b[i] && k) begin
                e[1] = 1'b1;
            end else if (b[i]) begin
                e[2] = 1'b1;
            end
        end
        return e;
    endfunction : model

    task automatic pulse(input logic [13:0] m, input logic stp);
        logic [3:0] e;
        e = model(shadow, m, stp);
        @(posedge i_clk);
        mon_event <= m;
        clock_stopped <= stp;
        @(posedge i_clk);
        mon_event <= 14'h0000;
        #1;
        check("reload outputs", {28'h0, standby, slow, fast, brk}, {28'h0, e});
        @(posedge i_clk);
        #1;
        check("outputs after pulse", {28'h0, standby, slow, fast, brk}, 32'h0);
    endtask : pulse

    task automatic t_regs();
        bus_read(devact_pkg::ENABLES_OFFSET, d);
        check("reset value", d, devact_pkg::ENABLES_RESET);
        bus_write(devact_pkg::ENABLES_OFFSET, 32'hA5C3_3C5A);
        bus_read(devact_pkg::ENABLES_OFFSET, d);
        check("readback", d, 32'hA5C3_3C5A);
        @(posedge i_clk);
        #1;
        check("read data after its cycle", rdata, 32'h0000_0000);
        // an unmapped write must leave the enables alone
        bus_write(8'h58, 32'hFFFF_FFFF);
        bus_read(8'h58, d);
        check("unmapped read", d, 32'h0000_0000);
        bus_read(devact_pkg::ENABLES_OFFSET, d);
        check("enables kept", d, 32'hA5C3_3C5A);
    endtask : t_regs

    task automatic t_standby();
        for (int n = 0; n < 14; n++) begin
            bus_write(devact_pkg::ENABLES_OFFSET, 32'h1 << n);
            pulse(14'h1 << n, 1'b0);
            pulse(~(14'h1 << n), 1'b0);
        end
    endtask : t_standby

    task automatic t_burst();
        // alternating select patterns give each picked monitor both values
        for (int n = 0; n < 14; n++) begin
            for (int s = 0; s < 2; s++) begin
                bus_write(devact_pkg::ENABLES_OFFSET,
                          (32'h1 << (14 + n)) | (s == 0 ? 32'h5000_0000 : 32'hA000_0000));
                pulse(14'h1 << n, 1'b0);
                pulse(~(14'h1 << n), 1'b0);
            end
        end
    endtask : t_burst

    task automatic t_break();
        bus_write(devact_pkg::ENABLES_OFFSET, 32'hFFFF_FFFF);
        pulse(14'h0024, 1'b1);
        pulse(14'h3FFF, 1'b0);
        bus_write(devact_pkg::ENABLES_OFFSET, 32'h0000_3FFF);
        pulse(14'h3FFF, 1'b1);
    endtask : t_break

    task automatic t_both();
        bus_write(devact_pkg::ENABLES_OFFSET, 32'h2FFF_FFFF);
        pulse(14'h0026, 1'b0);
        pulse(14'h0002, 1'b0);
    endtask : t_both

    // status record: write one to clear, then a write followed at once by an event,
    // with a clear of the record in the same cycle as that event
    task automatic t_seen();
        bus_write(devact_pkg::SEEN_OFFSET, 32'hFFFF_FFFF);
        bus_read(devact_pkg::SEEN_OFFSET, d);
        check("seen cleared", d, devact_pkg::SEEN_RESET);
        @(posedge i_clk);
        addr <= devact_pkg::ENABLES_OFFSET;
        wdata <= 32'h0000_0001;
        wr <= 1'b1;
        clock_stopped <= 1'b0;
        @(posedge i_clk);
        addr <= devact_pkg::SEEN_OFFSET;
        wdata <= 32'hFFFF_FFFF;
        mon_event <= 14'h0001;
        @(posedge i_clk);
        wr <= 1'b0;
        mon_event <= 14'h0000;
        shadow = 32'h0000_0001;
        #1;
        check("standby after write", {31'h0, standby}, 32'h0000_0001);
        bus_read(devact_pkg::SEEN_OFFSET, d);
        check("seen set beats clear", d,
              (32'h1 << devact_pkg::SEEN_MON_LSB) | (32'h1 << devact_pkg::SEEN_STANDBY));
    endtask : t_seen

    initial begin
        i_arst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        mon_event = 14'h0000;
        clock_stopped = 1'b0;
        shadow = 32'h0000_0000;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_regs();
        t_standby();
        t_burst();
        t_break();
        t_both();
        t_seen();
        finish_test();
    end
endmodule : device_activity_reload_enables_tb_top
